// ### can_trx_consts.svh
/*
  Timing constants and mode encodings for the CAN transceiver mode control.
  Assumes a 20 MHz mclk; included by bare name.
*/
`ifndef CAN_TRX_CONSTS_SVH
`define CAN_TRX_CONSTS_SVH
`define CLK_PERIOD_NS      50
`define TEN_TIME_NS        10000
`define TEN_CYCLES         ((`TEN_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TRX_MODE_OFF       2'h0
`define TRX_MODE_WAKE      2'h1
`define TRX_MODE_RXONLY    2'h2
`define TRX_MODE_NORMAL    2'h3
`define FIFO_DEPTH_DEF     8
`endif

// ### can_trx_pkg.sv
/*
  Types shared by the CAN transceiver mode control.
  Assumes the consts header carries the encodings.
*/
package can_trx_pkg;
  typedef enum logic [1:0] {CHIP_NORMAL, CHIP_STOP, CHIP_SLEEP, CHIP_FAILSAFE} chipMode_t;
  typedef logic [1:0] trxMode_t;
endpackage

// ### bit_stream_if.sv
/*
  Valid/ready stream of bus samples between the control and its FIFO.
  Assumes one clock domain.
*/
`timescale 1ns/1ns
`default_nettype none
interface bit_stream_if #(parameter int W = 1);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ### sample_fifo.sv
/*
  Flip-flop FIFO with valid/ready on both sides.
  Assumes one clock and an active-low asynchronous reset.
*/
`timescale 1ns/1ns
`default_nettype none
module sample_fifo #(
  parameter int W     = 1,
  parameter int DEPTH = 8
) (
  input  wire logic  mclk,
  input  wire logic  arst_n,
  bit_stream_if.snk  inS,
  bit_stream_if.src  outS
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_r [DEPTH];
  logic [W-1:0] mem_nxt [DEPTH];
  logic [AW-1:0] wrPtr_r, wrPtr_nxt, rdPtr_r, rdPtr_nxt;
  logic [AW:0]   count_r, count_nxt;
  logic          push, pop;

  // ****************************************
  // Next state
  // ****************************************
  assign inS.ready  = (count_r != (AW+1)'(DEPTH));
  assign outS.valid = (count_r != '0);
  assign outS.data  = mem_r[rdPtr_r];
  assign push = inS.valid & inS.ready;
  assign pop  = outS.valid & outS.ready;

  always_comb
  begin
    mem_nxt   = mem_r;
    wrPtr_nxt = wrPtr_r;
    rdPtr_nxt = rdPtr_r;
    count_nxt = count_r;
    if (push)
    begin
      mem_nxt[wrPtr_r] = inS.data;
      wrPtr_nxt = (wrPtr_r == AW'(DEPTH-1)) ? '0 : wrPtr_r + 1'b1;
    end
    if (pop)
      rdPtr_nxt = (rdPtr_r == AW'(DEPTH-1)) ? '0 : rdPtr_r + 1'b1;
    if (push && !pop)
      count_nxt = count_r + 1'b1;
    else if (pop && !push)
      count_nxt = count_r - 1'b1;
  end

  // ****************************************
  // Registers
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < DEPTH; g++)
    begin : gMem
      always_ff @(posedge mclk or negedge arst_n)
      begin
        if (!arst_n)
          mem_r[g] <= '0;
        else
          mem_r[g] <= mem_nxt[g];
      end
    end
  endgenerate

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end
    else
    begin
      wrPtr_r <= wrPtr_nxt;
      rdPtr_r <= rdPtr_nxt;
      count_r <= count_nxt;
    end
  end
endmodule
`default_nettype wire

// ### can_trx_wait_timer.sv
/*
  Enabling-wait counter: loads on start, counts down, flags done.
  Assumes one clock and an active-low asynchronous reset.
*/
`timescale 1ns/1ns
`default_nettype none
`include "can_trx_consts.svh"
module can_trx_wait_timer #(
  parameter int CYCLES = `TEN_CYCLES
) (
  input  wire logic mclk,
  input  wire logic arst_n,
  input  wire logic start,
  input  wire logic run,
  output logic      done
);
  localparam int CW = $clog2(CYCLES + 1);
  logic [CW-1:0] cnt_r, cnt_nxt;

  always_comb
  begin
    cnt_nxt = cnt_r;
    if (!run)
      cnt_nxt = '0;
    else if (start)
      cnt_nxt = CW'(CYCLES);
    else if (cnt_r != '0)
      cnt_nxt = cnt_r - 1'b1;
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      cnt_r <= '0;
    else
      cnt_r <= cnt_nxt;
  end

  assign done = run && !start && (cnt_r == '0);
endmodule
`default_nettype wire

// ### can_transceiver_mode_control.sv
/*
  Mode control and data-path gating of the CAN transceiver: off, wake
  capable, receive only and normal modes, the enabling wait, and bus wake.
  Assumes tx_data_in, busRxLevel and busWakeEvent are synchronous to mclk.
*/
//Contract
//- Off mode after reset; allowed in every chip mode
//- Bus wake ignored while off
//- Normal mode only in chip normal mode
//- Driver copies transmit input; low is dominant
//- Dominant begun before wait end not forwarded
//- Receiver converts bus level to receive output
//- Receive-only disables driver, keeps reception
//- Receive-only allowed in chip normal or stop
//- Wake capable mode detects bus wake event
//- After wake, mode stays 01, output low
//- Rearm on stop/sleep/failsafe entry or toggle
`timescale 1ns/1ns
`default_nettype none
`include "can_trx_consts.svh"
module can_transceiver_mode_control #(
  parameter int WAIT_CYCLES = `TEN_CYCLES,
  parameter int FIFO_DEPTH  = `FIFO_DEPTH_DEF
) (
  input  wire logic                mclk,
  input  wire logic                arst_n,
  input  wire can_trx_pkg::chipMode_t chipMode,
  input  wire can_trx_pkg::trxMode_t  modeReq,
  input  wire logic                modeReqStb,
  input  wire logic                tx_data_in,
  input  wire logic                busRxLevel,
  input  wire logic                busWakeEvent,
  output logic                     busDriveDom,
  output logic                     busDriveEn,
  output logic                     rx_data_out,
  output can_trx_pkg::trxMode_t    trxMode,
  output logic                     wakeFlag
);
  import can_trx_pkg::*;

  typedef enum {TX_GATED, TX_SEEN_HIGH, TX_OPEN} txGate_t;

  trxMode_t  mode_r, mode_nxt;
  chipMode_t chipPrev_r, chipPrev_nxt;
  txGate_t   gate_r, gate_nxt;
  logic      armed_r, armed_nxt;
  logic      woken_r, woken_nxt;
  logic      drvEn_r, drvEn_nxt;
  logic      drvDom_r, drvDom_nxt;
  logic      rxOut_r, rxOut_nxt;
  logic      wakeFlag_r, wakeFlag_nxt;
  logic      enterNormal, waitDone, reqOk, rearmChip;

  bit_stream_if #(.W(1)) toFifo ();
  bit_stream_if #(.W(1)) fromFifo ();

  // ****************************************
  // Mode selection
  // ****************************************
  always_comb
  begin
    unique case (modeReq)
      `TRX_MODE_NORMAL: reqOk = (chipMode == CHIP_NORMAL);
      `TRX_MODE_RXONLY: reqOk = (chipMode == CHIP_NORMAL) || (chipMode == CHIP_STOP);
      default:          reqOk = 1'b1;
    endcase
  end

  // Entry into a low-power chip mode rearms wake monitoring
  assign rearmChip = (chipMode != chipPrev_r) &&
                     (chipMode == CHIP_STOP || chipMode == CHIP_SLEEP || chipMode == CHIP_FAILSAFE);
  assign enterNormal = modeReqStb && reqOk && (modeReq == `TRX_MODE_NORMAL) && (mode_r != `TRX_MODE_NORMAL);

  always_comb
  begin
    mode_nxt     = mode_r;
    chipPrev_nxt = chipMode;
    armed_nxt    = armed_r;
    woken_nxt    = woken_r;
    wakeFlag_nxt = 1'b0;
    if (modeReqStb && reqOk && modeReq != mode_r)
    begin
      mode_nxt  = modeReq;
      armed_nxt = 1'b1;
      woken_nxt = 1'b0;
    end
    else if (rearmChip)
      armed_nxt = 1'b1;
    // Chip mode dropped out of its allowed set: fall back to off
    if (mode_nxt == `TRX_MODE_NORMAL && chipMode != CHIP_NORMAL)
      mode_nxt = `TRX_MODE_OFF;
    if (mode_nxt == `TRX_MODE_RXONLY && chipMode != CHIP_NORMAL && chipMode != CHIP_STOP)
      mode_nxt = `TRX_MODE_OFF;
    // Wake only counts while armed in wake capable mode; off ignores it
    if (mode_r == `TRX_MODE_WAKE && mode_nxt == `TRX_MODE_WAKE && armed_r && busWakeEvent)
    begin
      armed_nxt    = 1'b0;
      woken_nxt    = 1'b1;
      wakeFlag_nxt = 1'b1;
    end
  end

  // ****************************************
  // Transmit gating
  // ****************************************
  can_trx_wait_timer #(.CYCLES(WAIT_CYCLES)) uTimer (
    .mclk   (mclk),
    .arst_n (arst_n),
    .start  (enterNormal),
    .run    (mode_nxt == `TRX_MODE_NORMAL),
    .done   (waitDone)
  );

  always_comb
  begin
    gate_nxt = gate_r;
    if (mode_r != `TRX_MODE_NORMAL || enterNormal)
      gate_nxt = TX_GATED;
    else
    begin
      unique case (gate_r)
        TX_GATED:     if (waitDone) gate_nxt = tx_data_in ? TX_OPEN : TX_SEEN_HIGH;
        TX_SEEN_HIGH: if (tx_data_in) gate_nxt = TX_OPEN;
        TX_OPEN:      gate_nxt = TX_OPEN;
      endcase
    end
  end

  // Samples pass the FIFO, drained every cycle in every mode; the driver
  // takes tx_data_in directly, not the FIFO output.
  assign toFifo.valid  = 1'b1;
  assign toFifo.data   = tx_data_in;
  assign fromFifo.ready = 1'b1;

  sample_fifo #(.W(1), .DEPTH(FIFO_DEPTH)) uFifo (
    .mclk   (mclk),
    .arst_n (arst_n),
    .inS    (toFifo.snk),
    .outS   (fromFifo.src)
  );

  always_comb
  begin
    drvEn_nxt  = (mode_r == `TRX_MODE_NORMAL) && (gate_r == TX_OPEN);
    drvDom_nxt = drvEn_nxt && !tx_data_in;
    if (woken_nxt && mode_nxt == `TRX_MODE_WAKE)
      rxOut_nxt = 1'b0;
    else if (mode_nxt == `TRX_MODE_NORMAL || mode_nxt == `TRX_MODE_RXONLY)
      rxOut_nxt = busRxLevel;
    else
      rxOut_nxt = 1'b1;
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mode_r     <= `TRX_MODE_OFF;
      chipPrev_r <= CHIP_NORMAL;
      gate_r     <= TX_GATED;
      armed_r    <= 1'b1;
      woken_r    <= 1'b0;
      drvEn_r    <= 1'b0;
      drvDom_r   <= 1'b0;
      rxOut_r    <= 1'b1;
      wakeFlag_r <= 1'b0;
    end
    else
    begin
      mode_r     <= mode_nxt;
      chipPrev_r <= chipPrev_nxt;
      gate_r     <= gate_nxt;
      armed_r    <= armed_nxt;
      woken_r    <= woken_nxt;
      drvEn_r    <= drvEn_nxt;
      drvDom_r   <= drvDom_nxt;
      rxOut_r    <= rxOut_nxt;
      wakeFlag_r <= wakeFlag_nxt;
    end
  end

  assign busDriveEn  = drvEn_r;
  assign busDriveDom = drvDom_r;
  assign rx_data_out = rxOut_r;
  assign trxMode     = mode_r;
  assign wakeFlag    = wakeFlag_r;

  // ****************************************
  // Assertions
  // ****************************************
  // Cycles since normal entry; saturates so a long run never wraps back into the wait
  logic [31:0] sinceEn_r, sinceEn_nxt;

  always_comb
  begin
    sinceEn_nxt = sinceEn_r;
    if (enterNormal)
      sinceEn_nxt = '0;
    else if (sinceEn_r != '1)
      sinceEn_nxt = sinceEn_r + 1'b1;
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      sinceEn_r <= '1;
    else
      sinceEn_r <= sinceEn_nxt;
  end

  property p_offNoWake;
    @(posedge mclk) disable iff (!arst_n)
    (mode_r == `TRX_MODE_OFF) |=> !wakeFlag_r;
  endproperty
  a_offNoWake: assert property (p_offNoWake)
    else $error("Wake flagged while off");

  property p_offStopped;
    @(posedge mclk) disable iff (!arst_n)
    (mode_r == `TRX_MODE_OFF) |=> !busDriveEn;
  endproperty
  a_offStopped: assert property (p_offStopped)
    else $error("Driver on while off");

  property p_normalOnlyChipNormal;
    @(posedge mclk) disable iff (!arst_n)
    (mode_r == `TRX_MODE_NORMAL) |-> $past(chipMode) == CHIP_NORMAL;
  endproperty
  a_normalOnlyChipNormal: assert property (p_normalOnlyChipNormal)
    else $error("Normal mode outside chip normal");

  property p_rxOnlyChip;
    @(posedge mclk) disable iff (!arst_n)
    (mode_r == `TRX_MODE_RXONLY) |-> ($past(chipMode) == CHIP_NORMAL || $past(chipMode) == CHIP_STOP);
  endproperty
  a_rxOnlyChip: assert property (p_rxOnlyChip)
    else $error("Receive only in wrong chip mode");

  property p_driveFollows;
    @(posedge mclk) disable iff (!arst_n)
    busDriveEn |-> (busDriveDom == !$past(tx_data_in));
  endproperty
  a_driveFollows: assert property (p_driveFollows)
    else $error("Driver not following transmit input");

  // The FIFO is drained every cycle, so its head is always last cycle's sample
  property p_fifoTracks;
    @(posedge mclk) disable iff (!arst_n)
    fromFifo.valid |-> (toFifo.ready && fromFifo.data == $past(tx_data_in));
  endproperty
  a_fifoTracks: assert property (p_fifoTracks)
    else $error("Sample FIFO lost its fixed latency");

  property p_rxOnlyNoDrive;
    @(posedge mclk) disable iff (!arst_n)
    (mode_r == `TRX_MODE_RXONLY) |=> !busDriveEn;
  endproperty
  a_rxOnlyNoDrive: assert property (p_rxOnlyNoDrive)
    else $error("Driver on in receive only");

  property p_rxFollows;
    @(posedge mclk) disable iff (!arst_n)
    (mode_nxt == `TRX_MODE_RXONLY) |=> (rx_data_out == $past(busRxLevel));
  endproperty
  a_rxFollows: assert property (p_rxFollows)
    else $error("Receive output not following bus");

  sequence s_enterNormal;
    enterNormal && chipMode == CHIP_NORMAL;
  endsequence
  property p_waitGate;
    @(posedge mclk) disable iff (!arst_n)
    s_enterNormal |=> !busDriveEn [*2];
  endproperty
  a_waitGate: assert property (p_waitGate)
    else $error("Driver enabled inside enabling wait");

  // Earliest legal drive: wait expiry, one cycle to open the gate, one to register
  property p_waitCount;
    @(posedge mclk) disable iff (!arst_n)
    busDriveEn |-> (sinceEn_r >= 32'(WAIT_CYCLES + 2));
  endproperty
  a_waitCount: assert property (p_waitCount)
    else $error("Driver enabled before enabling wait expired");

  property p_wakeHoldsLow;
    @(posedge mclk) disable iff (!arst_n)
    wakeFlag_r |-> (!rx_data_out && trxMode == `TRX_MODE_WAKE);
  endproperty
  a_wakeHoldsLow: assert property (p_wakeHoldsLow)
    else $error("Wake not held on receive output");

  property p_wokenStays;
    @(posedge mclk) disable iff (!arst_n)
    (woken_r && mode_r == `TRX_MODE_WAKE && !(modeReqStb && reqOk && modeReq != mode_r))
      |=> (!rx_data_out && trxMode == `TRX_MODE_WAKE);
  endproperty
  a_wokenStays: assert property (p_wokenStays)
    else $error("Receive output released without a mode change");

  property p_wakeDetect;
    @(posedge mclk) disable iff (!arst_n)
    (mode_r == `TRX_MODE_WAKE && mode_nxt == `TRX_MODE_WAKE && armed_r && busWakeEvent) |=> wakeFlag_r;
  endproperty
  a_wakeDetect: assert property (p_wakeDetect)
    else $error("Bus wake missed");

  sequence s_modeChange;
    modeReqStb && reqOk && modeReq != mode_r;
  endsequence
  property p_rearmToggle;
    @(posedge mclk) disable iff (!arst_n)
    s_modeChange |=> (armed_r && !woken_r);
  endproperty
  a_rearmToggle: assert property (p_rearmToggle)
    else $error("Mode change did not rearm wake");

  property p_rearmChip;
    @(posedge mclk) disable iff (!arst_n)
    (rearmChip && !busWakeEvent) |=> armed_r;
  endproperty
  a_rearmChip: assert property (p_rearmChip)
    else $error("Low power chip entry did not rearm wake");
endmodule
`default_nettype wire

// ### can_ctrl_model.sv
/*
  Model of the CAN protocol controller driving the transmit input.
  Assumes enStart pulses in the cycle that normal mode is requested.
*/
`timescale 1ns/1ns
`default_nettype none
module can_ctrl_model #(
  parameter int WAIT = 4
) (
  input  wire logic mclk,
  input  wire logic arst_n,
  input  wire logic enStart,
  input  wire logic early,
  input  wire logic want,
  output logic      txOut
);
  int cnt_r;
  int cnt_nxt;
  // **********************
  // Enabling wait tracking
  // **********************
  always_comb
  begin
    cnt_nxt = cnt_r;
    if (enStart)
      cnt_nxt = 0;
    else if (cnt_r < WAIT + 2)
      cnt_nxt = cnt_r + 1;
  end
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      cnt_r <= WAIT + 2;
    else
      cnt_r <= cnt_nxt;
  end
  // Margin of two cycles covers the request latency; early breaks it on purpose
  assign txOut = (cnt_r < WAIT + 2 && !early) ? 1'b1 : want;
endmodule
`default_nettype wire

// ### can_transceiver_mode_control_bench.sv
/*
  Self-checking bench for the transceiver mode control.
  Assumes the controller model and the design files are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
`include "can_trx_consts.svh"
module can_transceiver_mode_control_bench;
  import can_trx_pkg::*;
  localparam int WAIT = 4;
  logic      mclk;
  logic      arst_n;
  chipMode_t chipMode;
  trxMode_t  modeReq;
  logic      modeReqStb;
  logic      txLine;
  logic      busRxLevel;
  logic      busWakeEvent;
  logic      enStart;
  logic      early;
  logic      want;
  logic      busDriveDom;
  logic      busDriveEn;
  logic      rx_data_out;
  trxMode_t  trxMode;
  logic      wakeFlag;
  int        badCount;
  int        numChecks;

  can_transceiver_mode_control #(.WAIT_CYCLES(WAIT)) uut (
    .mclk(mclk), .arst_n(arst_n), .chipMode(chipMode), .modeReq(modeReq),
    .modeReqStb(modeReqStb), .tx_data_in(txLine), .busRxLevel(busRxLevel),
    .busWakeEvent(busWakeEvent), .busDriveDom(busDriveDom), .busDriveEn(busDriveEn),
    .rx_data_out(rx_data_out), .trxMode(trxMode), .wakeFlag(wakeFlag)
  );
  can_ctrl_model #(.WAIT(WAIT)) ctrl (
    .mclk(mclk), .arst_n(arst_n), .enStart(enStart), .early(early), .want(want), .txOut(txLine)
  );

  // **************
  // Shared helpers
  // **************
  task automatic chk(input string name, input logic [1:0] exp, input logic [1:0] got);
    numChecks++;
    if (got !== exp)
    begin
      badCount++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic req(input trxMode_t m);
    @(posedge mclk);
    modeReq    <= m;
    modeReqStb <= 1'b1;
    enStart    <= (m == `TRX_MODE_NORMAL);
    @(posedge mclk);
    modeReqStb <= 1'b0;
    enStart    <= 1'b0;
    @(negedge mclk);
  endtask
  task automatic wake();
    @(posedge mclk);
    busWakeEvent <= 1'b1;
    @(posedge mclk);
    busWakeEvent <= 1'b0;
    @(negedge mclk);
  endtask
  task automatic endSim();
    $display("checks %0d mismatches %0d", numChecks, badCount);
    if (badCount == 0 && numChecks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // *********
  // Scenarios
  // *********
  task automatic t_gating();
    @(negedge mclk);
    chk("mode", `TRX_MODE_OFF, trxMode);
    chk("rx", 2'h1, {1'b0, rx_data_out});
    @(posedge mclk);
    chipMode <= CHIP_FAILSAFE;
    req(`TRX_MODE_RXONLY);
    chk("mode", `TRX_MODE_OFF, trxMode);
    @(posedge mclk);
    chipMode <= CHIP_SLEEP;
    req(`TRX_MODE_NORMAL);
    chk("mode", `TRX_MODE_OFF, trxMode);
    req(`TRX_MODE_RXONLY);
    chk("mode", `TRX_MODE_OFF, trxMode);
    @(posedge mclk);
    chipMode <= CHIP_STOP;
    req(`TRX_MODE_RXONLY);
    chk("mode", `TRX_MODE_RXONLY, trxMode);
    req(`TRX_MODE_NORMAL);
    chk("mode", `TRX_MODE_RXONLY, trxMode);
    req(`TRX_MODE_OFF);
    chk("mode", `TRX_MODE_OFF, trxMode);
    $display("test gating done");
  endtask
  task automatic t_normal();
    @(posedge mclk);
    chipMode <= CHIP_NORMAL;
    early    <= 1'b1;
    want     <= 1'b0;
    req(`TRX_MODE_NORMAL);
    chk("mode", `TRX_MODE_NORMAL, trxMode);
    repeat (WAIT + 4) @(negedge mclk);
    chk("drvEn", 2'h0, {1'b0, busDriveEn});
    @(posedge mclk);
    want <= 1'b1;
    repeat (4) @(negedge mclk);
    chk("drvEn", 2'h1, {1'b0, busDriveEn});
    chk("dom", 2'h0, {1'b0, busDriveDom});
    @(posedge mclk);
    want <= 1'b0;
    busRxLevel <= 1'b0;
    @(posedge mclk);
    @(negedge mclk);
    chk("dom", 2'h1, {1'b0, busDriveDom});
    chk("rx", 2'h0, {1'b0, rx_data_out});
    // Second entry with a well-behaved controller that wants dominant at once
    @(posedge mclk);
    want  <= 1'b0;
    early <= 1'b0;
    req(`TRX_MODE_OFF);
    req(`TRX_MODE_NORMAL);
    repeat (3) @(negedge mclk);
    chk("drvEn", 2'h0, {1'b0, busDriveEn});
    repeat (5) @(negedge mclk);
    chk("drvEn", 2'h1, {1'b0, busDriveEn});
    chk("dom", 2'h1, {1'b0, busDriveDom});
    @(posedge mclk);
    want <= 1'b1;
    $display("test normal done");
  endtask
  task automatic t_rxonly();
    req(`TRX_MODE_RXONLY);
    @(negedge mclk);
    chk("drvEn", 2'h0, {1'b0, busDriveEn});
    @(posedge mclk);
    busRxLevel <= 1'b1;
    repeat (2) @(negedge mclk);
    chk("rx", 2'h1, {1'b0, rx_data_out});
    @(posedge mclk);
    busRxLevel <= 1'b0;
    repeat (2) @(negedge mclk);
    chk("rx", 2'h0, {1'b0, rx_data_out});
    $display("test rxonly done");
  endtask
  task automatic t_wake();
    @(posedge mclk);
    busRxLevel <= 1'b1;
    req(`TRX_MODE_OFF);
    wake();
    chk("wake", 2'h0, {1'b0, wakeFlag});
    req(`TRX_MODE_WAKE);
    wake();
    chk("wake", 2'h1, {1'b0, wakeFlag});
    @(negedge mclk);
    chk("wake", 2'h0, {1'b0, wakeFlag});
    chk("mode", `TRX_MODE_WAKE, trxMode);
    chk("rx", 2'h0, {1'b0, rx_data_out});
    wake();
    chk("wake", 2'h0, {1'b0, wakeFlag});
    @(posedge mclk);
    chipMode <= CHIP_STOP;
    repeat (2) @(negedge mclk);
    chk("rx", 2'h0, {1'b0, rx_data_out});
    wake();
    chk("wake", 2'h1, {1'b0, wakeFlag});
    req(`TRX_MODE_RXONLY);
    chk("rx", 2'h1, {1'b0, rx_data_out});
    req(`TRX_MODE_WAKE);
    wake();
    chk("wake", 2'h1, {1'b0, wakeFlag});
    $display("test wake done");
  endtask

  // ***********
  // Main flow
  // ***********
  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  initial
  begin
    arst_n = 1'b0;
    chipMode = CHIP_NORMAL;
    modeReq = `TRX_MODE_OFF;
    modeReqStb = 1'b0;
    busRxLevel = 1'b1;
    busWakeEvent = 1'b0;
    enStart = 1'b0;
    early = 1'b0;
    want = 1'b1;
    badCount = 0;
    numChecks = 0;
    repeat (2) @(posedge mclk);
    arst_n <= 1'b1;
    t_gating();
    t_normal();
    t_rxonly();
    t_wake();
    endSim();
  end
  // Whole run is under 200 cycles; ten times that means a hang
  initial
  begin
    #(2000 * 50);
    badCount++;
    endSim();
  end
endmodule
`default_nettype wire
